// ### verilog/dio_pkg.sv
/*
 * Constants of the I/O conditioning block: access addresses,
 * field positions, reset values, routing codes, sampling period.
 * Assumes a 25 MHz clock.
 */
package dio_pkg;

    // ------------------------------------------------------------
    // Pin counts
    // ------------------------------------------------------------
    localparam int NUM_PINS = 6;
    localparam int NUM_FLEX = 4;
    localparam int NUM_SENSORS = 6;

    // ------------------------------------------------------------
    // Access addresses
    // ------------------------------------------------------------
    localparam logic [15:0] IDX_FLEX_CFG = 16'h3321;
    localparam logic [7:0] SUB_DIR_MASK = 8'h01;
    localparam logic [7:0] SUB_PULL_MASK = 8'h02;
    localparam logic [15:0] IDX_IN_CTRL = 16'h3240;
    localparam logic [7:0] SUB_SF_EN = 8'h01;
    localparam logic [7:0] SUB_INVERT = 8'h02;
    localparam logic [7:0] SUB_FORCE_EN = 8'h03;
    localparam logic [7:0] SUB_FORCE_VAL = 8'h04;
    localparam logic [7:0] SUB_RAW = 8'h05;
    localparam logic [7:0] SUB_ROUTE_EN = 8'h08;
    localparam logic [15:0] IDX_ROUTE_SEL = 16'h3242;
    localparam logic [7:0] SUB_ROUTE_FIRST = 8'h01;
    localparam logic [7:0] SUB_ROUTE_LAST = 8'h20;
    localparam logic [15:0] IDX_IN_IMAGE = 16'h60fd;
    localparam logic [7:0] SUB_IN_IMAGE = 8'h00;
    localparam logic [15:0] IDX_OUT_IMAGE = 16'h60fe;
    localparam logic [7:0] SUB_OUT_IMAGE = 8'h01;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int LEVEL_BASE = 16;
    localparam int SF_NEG_LIMIT = 0;
    localparam int SF_POS_LIMIT = 1;
    localparam int SF_HOME = 2;
    localparam int OUT_BRAKE_BIT = 0;
    localparam int STEP_PIN = 1;
    localparam int DIR_PIN = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0] DIR_MASK_RST = 4'h0;
    localparam logic [3:0] PULL_MASK_RST = 4'h0;
    localparam logic [31:0] CTRL_WORD_RST = 32'h0;
    localparam logic [31:0] OUT_IMAGE_RST = 32'h0;
    localparam logic [7:0] ROUTE_SEL_RST = 8'h00;

    // ------------------------------------------------------------
    // Routing source codes
    // ------------------------------------------------------------
    localparam logic [6:0] SRC_ZERO = 7'h00;
    localparam logic [6:0] SRC_PHYS_FIRST = 7'h01;
    localparam logic [6:0] SRC_PHYS_LAST = 7'h10;
    localparam logic [6:0] SRC_SENS_FIRST = 7'h41;
    localparam logic [6:0] SRC_SENS_LAST = 7'h46;
    localparam int SRC_INVERT_BIT = 7;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int SAMPLE_PERIOD_NS = 1000000;
    localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int SAMPLE_CNT_W = 16;

endpackage

// ### verilog/dio_sampler.sv
/*
 * Two-flop synchroniser and millisecond sampler.
 * Assumes asynchronous inputs.
 */
`timescale 1ns/10ps
module dio_sampler
    import dio_pkg::*;
#(
    parameter int WIDTH = 12,
    parameter int PERIOD = SAMPLE_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out,
    output logic [WIDTH-1:0] sample_out,
    output logic [WIDTH-1:0] filt_out
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;
    logic [SAMPLE_CNT_W-1:0] cnt_r;
    logic [WIDTH-1:0] samp_r;
    logic [WIDTH-1:0] filt_r;
    wire tick = (cnt_r == SAMPLE_CNT_W'(PERIOD - 1));

    // ------------------------------------------------------------
    // Two-stage synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_r <= '0;
            sync_r <= '0;
        end else if (ce_in) begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    // ------------------------------------------------------------
    // Millisecond sampling
    // ------------------------------------------------------------
    // sample once per millisecond
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_r <= '0;
            samp_r <= '0;
            filt_r <= '0;
        end else if (ce_in) begin
            cnt_r <= tick ? '0 : cnt_r + 1'b1;
            if (tick) begin
                samp_r <= sync_r;
                filt_r <= (sync_r & samp_r) | (filt_r & (sync_r | samp_r));
            end
        end
    end

    assign sync_out = sync_r;
    assign sample_out = samp_r;
    assign filt_out = filt_r;

endmodule

// ### verilog/digital_io_conditioning.sv
/*
 * Digital I/O conditioning: six pins, four bidirectional, pulls,
 * input processing, routing and both images behind an access port.
 * Assumes asynchronous pins and sensors;
 * the pad resolves pulls.
 */
`timescale 1ns/10ps
// How it works
// - Six pins, first four bidirectional
// - Direction mask bit one makes output
// - Pull mask selects up, only for inputs
// - Image bits 0-5 carry special functions
// - Pin n level sits at bit 15+n
// - Output pins still read back as levels
// - Sample each millisecond, drop short pulses
// - Special enable gates only low bits
// - Bits 0,1,2: neg limit, pos limit, home
// - Inversion flips inputs except step/direction
// - Force enable substitutes software value
// - Force value gives the substituted level
// - Raw word shows unprocessed samples
// - Input 1 processed at 16, limit at 0
// - Input 2 steps, input 3 home/direction
// - Routing maps any source to any bit
// - Routing enable overrides normal processing
// - Selector k drives image bit k-1
// - Codes 0, 1-6, 65-70, plus 128 inverts
module digital_io_conditioning
    import dio_pkg::*;
#(
    parameter int SAMPLE_PERIOD = SAMPLE_CYCLES
) (
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    input wire logic CE_IN,
    input wire logic GP_PIN_ONE_IN,
    output logic GP_PIN_ONE_OUT,
    output logic GP_PIN_ONE_OE_OUT,
    input wire logic GP_PIN_TWO_STEP_IN,
    output logic GP_PIN_TWO_STEP_OUT,
    output logic GP_PIN_TWO_STEP_OE_OUT,
    input wire logic GP_PIN_THREE_DIR_IN,
    output logic GP_PIN_THREE_DIR_OUT,
    output logic GP_PIN_THREE_DIR_OE_OUT,
    input wire logic GP_PIN_FOUR_IN,
    output logic GP_PIN_FOUR_OUT,
    output logic GP_PIN_FOUR_OE_OUT,
    input wire logic GP_PIN_FIVE_IN,
    input wire logic GP_PIN_SIX_IN,
    input wire logic [NUM_SENSORS-1:0] SENSOR_IN,
    output logic [NUM_FLEX-1:0] PULL_UP_OUT,
    output logic [NUM_FLEX-1:0] PULL_DOWN_OUT,
    input wire logic OD_RD_IN,
    input wire logic OD_WR_IN,
    input wire logic [15:0] OD_INDEX_IN,
    input wire logic [7:0] OD_SUB_IN,
    input wire logic [31:0] OD_WDATA_IN,
    output logic [31:0] OD_RDATA_OUT,
    output logic OD_ACK_OUT,
    output logic OD_ERR_OUT,
    output logic [31:0] INPUT_IMAGE_OUT,
    output logic BRAKE_OUT,
    output logic STEP_OUT,
    output logic DIR_OUT
);

    // ------------------------------------------------------------
    // Routing source decode
    // ------------------------------------------------------------
    function automatic logic route_src(input logic [7:0] code, input logic [NUM_PINS-1:0] pins,
                                       input logic [NUM_SENSORS-1:0] sens);
        logic [6:0] base;
        logic val;
        base = code[6:0];
        val = 1'b0;
        if (base >= SRC_PHYS_FIRST && base < SRC_PHYS_FIRST + 7'(NUM_PINS)) begin
            val = pins[3'(base - SRC_PHYS_FIRST)];
        end else if (base >= SRC_SENS_FIRST && base <= SRC_SENS_LAST) begin
            val = sens[3'(base - SRC_SENS_FIRST)];
        end
        return val ^ code[SRC_INVERT_BIT];
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [NUM_FLEX-1:0] dir_mask_r;
    logic [NUM_FLEX-1:0] pull_mask_r;
    logic [31:0] sf_en_r;
    logic [31:0] invert_r;
    logic [31:0] force_en_r;
    logic [31:0] force_val_r;
    logic route_en_r;
    logic [7:0] route_sel_r [0:31];
    logic [31:0] out_image_r;
    logic [31:0] in_image_r;
    logic [31:0] rdata_r;
    logic ack_r;
    logic err_r;
    logic [NUM_FLEX-1:0] pin_out_r;
    logic [NUM_FLEX-1:0] pin_oe_r;
    logic [NUM_FLEX-1:0] pull_up_r;
    logic [NUM_FLEX-1:0] pull_dn_r;
    logic brake_r;
    logic step_r;
    logic dir_r;

    // ------------------------------------------------------------
    // Input sampling
    // ------------------------------------------------------------
    logic [NUM_PINS+NUM_SENSORS-1:0] sync_all;
    logic [NUM_PINS+NUM_SENSORS-1:0] samp_all;
    logic [NUM_PINS+NUM_SENSORS-1:0] filt_all;
    wire [NUM_PINS-1:0] pin_raw = {GP_PIN_SIX_IN, GP_PIN_FIVE_IN, GP_PIN_FOUR_IN,
                                   GP_PIN_THREE_DIR_IN, GP_PIN_TWO_STEP_IN, GP_PIN_ONE_IN};

    dio_sampler #(
        .WIDTH(NUM_PINS + NUM_SENSORS),
        .PERIOD(SAMPLE_PERIOD)
    ) u_sampler (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .ce_in(CE_IN),
        .async_in({SENSOR_IN, pin_raw}),
        .sync_out(sync_all),
        .sample_out(samp_all),
        .filt_out(filt_all)
    );

    wire [NUM_PINS-1:0] pin_filt = filt_all[NUM_PINS-1:0];
    wire [NUM_SENSORS-1:0] sens_filt = filt_all[NUM_PINS+NUM_SENSORS-1:NUM_PINS];
    wire [NUM_PINS-1:0] pin_sync = sync_all[NUM_PINS-1:0];

    // ------------------------------------------------------------
    // Input processing
    // ------------------------------------------------------------
    logic [NUM_PINS-1:0] proc_lvl;
    logic [NUM_PINS-1:0] special;
    logic [31:0] routed;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_proc
            assign proc_lvl[gi] = force_en_r[gi] ? force_val_r[gi] : (pin_filt[gi] ^ invert_r[gi]);
            assign special[gi] = proc_lvl[gi] & sf_en_r[gi];
        end
        for (gi = 0; gi < 32; gi++) begin : g_route
            assign routed[gi] = route_src(route_sel_r[gi], pin_filt, sens_filt);
        end
    endgenerate

    // input 1 at bits 16 and 0
    wire [31:0] normal_image = {{(16-NUM_PINS){1'b0}}, proc_lvl, {(16-NUM_PINS){1'b0}}, special};
    wire [31:0] in_image_nxt = route_en_r ? routed : normal_image;

    // ------------------------------------------------------------
    // Object-dictionary decode
    // ------------------------------------------------------------
    wire hit_dir = OD_INDEX_IN == IDX_FLEX_CFG && OD_SUB_IN == SUB_DIR_MASK;
    wire hit_pull = OD_INDEX_IN == IDX_FLEX_CFG && OD_SUB_IN == SUB_PULL_MASK;
    wire is_ctrl = OD_INDEX_IN == IDX_IN_CTRL;
    wire hit_sf = is_ctrl && OD_SUB_IN == SUB_SF_EN;
    wire hit_inv = is_ctrl && OD_SUB_IN == SUB_INVERT;
    wire hit_fen = is_ctrl && OD_SUB_IN == SUB_FORCE_EN;
    wire hit_fval = is_ctrl && OD_SUB_IN == SUB_FORCE_VAL;
    wire hit_raw = is_ctrl && OD_SUB_IN == SUB_RAW;
    wire hit_ren = is_ctrl && OD_SUB_IN == SUB_ROUTE_EN;
    wire hit_sel = OD_INDEX_IN == IDX_ROUTE_SEL && OD_SUB_IN >= SUB_ROUTE_FIRST && OD_SUB_IN <= SUB_ROUTE_LAST;
    wire hit_inimg = OD_INDEX_IN == IDX_IN_IMAGE && OD_SUB_IN == SUB_IN_IMAGE;
    wire hit_outimg = OD_INDEX_IN == IDX_OUT_IMAGE && OD_SUB_IN == SUB_OUT_IMAGE;
    wire [4:0] sel_idx = 5'(OD_SUB_IN - SUB_ROUTE_FIRST);
    wire hit_any = hit_dir | hit_pull | hit_sf | hit_inv | hit_fen | hit_fval | hit_raw | hit_ren
                   | hit_sel | hit_inimg | hit_outimg;
    wire wr_ok = OD_WR_IN & hit_any & ~hit_raw & ~hit_inimg;
    wire req = OD_RD_IN | OD_WR_IN;

    wire [31:0] raw_word = {{(32-NUM_PINS){1'b0}}, samp_all[NUM_PINS-1:0]};
    wire [31:0] rdata_nxt = hit_dir ? {28'h0, dir_mask_r} :
                            hit_pull ? {28'h0, pull_mask_r} :
                            hit_sf ? sf_en_r :
                            hit_inv ? invert_r :
                            hit_fen ? force_en_r :
                            hit_fval ? force_val_r :
                            hit_raw ? raw_word :
                            hit_ren ? {31'h0, route_en_r} :
                            hit_sel ? {24'h0, route_sel_r[sel_idx]} :
                            hit_inimg ? in_image_r :
                            hit_outimg ? out_image_r : 32'h0;

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            dir_mask_r <= DIR_MASK_RST;
            pull_mask_r <= PULL_MASK_RST;
            sf_en_r <= CTRL_WORD_RST;
            invert_r <= CTRL_WORD_RST;
            force_en_r <= CTRL_WORD_RST;
            force_val_r <= CTRL_WORD_RST;
            route_en_r <= 1'b0;
            out_image_r <= OUT_IMAGE_RST;
        end else if (CE_IN && wr_ok) begin
            if (hit_dir) begin
                dir_mask_r <= OD_WDATA_IN[NUM_FLEX-1:0];
            end
            if (hit_pull) begin
                pull_mask_r <= OD_WDATA_IN[NUM_FLEX-1:0];
            end
            if (hit_sf) begin
                sf_en_r <= OD_WDATA_IN;
            end
            if (hit_inv) begin
                invert_r <= OD_WDATA_IN;
            end
            if (hit_fen) begin
                force_en_r <= OD_WDATA_IN;
            end
            if (hit_fval) begin
                force_val_r <= OD_WDATA_IN;
            end
            if (hit_ren) begin
                route_en_r <= OD_WDATA_IN[0];
            end
            if (hit_outimg) begin
                out_image_r <= OD_WDATA_IN;
            end
        end
    end

    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            for (int k = 0; k < 32; k++) begin
                route_sel_r[k] <= ROUTE_SEL_RST;
            end
        end else if (CE_IN && wr_ok && hit_sel) begin
            route_sel_r[sel_idx] <= OD_WDATA_IN[7:0];
        end
    end

    // ------------------------------------------------------------
    // Access answer and input image
    // ------------------------------------------------------------
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            rdata_r <= 32'h0;
            ack_r <= 1'b0;
            err_r <= 1'b0;
            in_image_r <= 32'h0;
        end else if (CE_IN) begin
            ack_r <= req;
            err_r <= req & (~hit_any | (OD_WR_IN & (hit_raw | hit_inimg)));
            rdata_r <= OD_RD_IN ? rdata_nxt : 32'h0;
            in_image_r <= in_image_nxt;
        end
    end

    // ------------------------------------------------------------
    // Pin drivers, pulls and special outputs
    // ------------------------------------------------------------
    // only four pins drive
    wire [NUM_FLEX-1:0] pull_up_nxt = pull_mask_r & ~dir_mask_r;
    wire [NUM_FLEX-1:0] pull_dn_nxt = ~pull_mask_r & ~dir_mask_r;

    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pin_out_r <= '0;
            pin_oe_r <= '0;
            pull_up_r <= '0;
            pull_dn_r <= '1;
            brake_r <= 1'b0;
            step_r <= 1'b0;
            dir_r <= 1'b0;
        end else if (CE_IN) begin
            pin_out_r <= out_image_r[LEVEL_BASE +: NUM_FLEX];
            pin_oe_r <= dir_mask_r;
            pull_up_r <= pull_up_nxt;
            pull_dn_r <= pull_dn_nxt;
            brake_r <= out_image_r[OUT_BRAKE_BIT];
            step_r <= pin_sync[STEP_PIN];
            dir_r <= pin_sync[DIR_PIN];
        end
    end

    assign GP_PIN_ONE_OUT = pin_out_r[0];
    assign GP_PIN_ONE_OE_OUT = pin_oe_r[0];
    assign GP_PIN_TWO_STEP_OUT = pin_out_r[1];
    assign GP_PIN_TWO_STEP_OE_OUT = pin_oe_r[1];
    assign GP_PIN_THREE_DIR_OUT = pin_out_r[2];
    assign GP_PIN_THREE_DIR_OE_OUT = pin_oe_r[2];
    assign GP_PIN_FOUR_OUT = pin_out_r[3];
    assign GP_PIN_FOUR_OE_OUT = pin_oe_r[3];
    assign PULL_UP_OUT = pull_up_r;
    assign PULL_DOWN_OUT = pull_dn_r;
    assign OD_RDATA_OUT = rdata_r;
    assign OD_ACK_OUT = ack_r;
    assign OD_ERR_OUT = err_r;
    assign INPUT_IMAGE_OUT = in_image_r;
    assign BRAKE_OUT = brake_r;
    assign STEP_OUT = step_r;
    assign DIR_OUT = dir_r;

endmodule

// ### bench/digital_io_conditioning_checker.sv
/*
 * Port assertions, bound to the block.
 * Assumes one clock.
 */
`timescale 1ns/10ps
module digital_io_conditioning_checker
    import dio_pkg::*;
(
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    input wire logic CE_IN,
    input wire logic OD_RD_IN,
    input wire logic OD_WR_IN,
    input wire logic [15:0] OD_INDEX_IN,
    input wire logic [7:0] OD_SUB_IN,
    input wire logic [31:0] OD_WDATA_IN,
    input wire logic [31:0] OD_RDATA_OUT,
    input wire logic OD_ACK_OUT,
    input wire logic OD_ERR_OUT,
    input wire logic [31:0] INPUT_IMAGE_OUT,
    input wire logic GP_PIN_TWO_STEP_IN,
    input wire logic STEP_OUT,
    input wire logic GP_PIN_ONE_OE_OUT,
    input wire logic GP_PIN_TWO_STEP_OE_OUT,
    input wire logic GP_PIN_THREE_DIR_OE_OUT,
    input wire logic GP_PIN_FOUR_OE_OUT,
    input wire logic [3:0] PULL_UP_OUT,
    input wire logic [3:0] PULL_DOWN_OUT,
    input wire logic BRAKE_OUT
);
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (RST_IN);
    logic [2:0] up_r;
    logic rte_r;
    logic [1:0] rth_r;
    wire wr = CE_IN && OD_WR_IN;
    wire at_ctrl = OD_INDEX_IN == IDX_IN_CTRL;
    wire wr_dir = wr && OD_INDEX_IN == IDX_FLEX_CFG && OD_SUB_IN == SUB_DIR_MASK;
    wire wr_out = wr && OD_INDEX_IN == IDX_OUT_IMAGE && OD_SUB_IN == SUB_OUT_IMAGE;
    wire wr_rte = wr && at_ctrl && OD_SUB_IN == SUB_ROUTE_EN;
    wire wr_ro = wr && ((at_ctrl && OD_SUB_IN == SUB_RAW) || OD_INDEX_IN == IDX_IN_IMAGE);
    wire [3:0] oe = {GP_PIN_FOUR_OE_OUT, GP_PIN_THREE_DIR_OE_OUT, GP_PIN_TWO_STEP_OE_OUT, GP_PIN_ONE_OE_OUT};
    wire normal = !rte_r && rth_r == 2'h0;
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            up_r <= 3'h0;
            rte_r <= 1'b0;
            rth_r <= 2'h0;
        end else begin
            up_r <= (up_r == 3'h7) ? up_r : up_r + 3'h1;
            rte_r <= wr_rte ? OD_WDATA_IN[0] : rte_r;
            rth_r <= {rth_r[0], rte_r};
        end
    end
    AST_ACK_AFTER_REQ:
        assert property (CE_IN && (OD_RD_IN || OD_WR_IN) |=> OD_ACK_OUT) else $error("no ack");
    AST_NO_SPURIOUS_ACK:
        assert property (CE_IN && !OD_RD_IN && !OD_WR_IN |=> !OD_ACK_OUT) else $error("stray ack");
    AST_RDATA_IDLE:
        assert property (!OD_ACK_OUT |-> OD_RDATA_OUT == 32'h0) else $error("read data off ack");
    AST_ERR_WITH_ACK:
        assert property (OD_ERR_OUT |-> OD_ACK_OUT) else $error("error without ack");
    AST_RO_WRITE_REFUSED:
        assert property (wr_ro |=> OD_ERR_OUT) else $error("ro write taken");
    AST_DIR_TO_OE:
        assert property (wr_dir |-> ##2 (oe == $past(OD_WDATA_IN[3:0], 2))) else $error("enable not mask");
    AST_PULL_PER_DIR:
        assert property (((PULL_UP_OUT ^ PULL_DOWN_OUT) == ~oe) && ((PULL_UP_OUT & PULL_DOWN_OUT) == 4'h0))
        else $error("pull request wrong");
    AST_BRAKE_FROM_IMAGE:
        assert property (wr_out |-> ##2 (BRAKE_OUT == $past(OD_WDATA_IN[0], 2))) else $error("brake wrong");
    AST_SF_GATED:
        assert property (normal |-> ((INPUT_IMAGE_OUT[5:0] & ~INPUT_IMAGE_OUT[21:16]) == 6'h0)
            && INPUT_IMAGE_OUT[15:6] == 10'h0 && INPUT_IMAGE_OUT[31:22] == 10'h0) else $error("image bits");
    AST_STEP_RAW:
        assert property (up_r == 3'h7 |-> STEP_OUT == $past(GP_PIN_TWO_STEP_IN, 3)) else $error("step path");
    cover property (wr_dir);
    cover property (OD_ERR_OUT);
    cover property (rte_r && OD_ACK_OUT);
    cover property ($rose(STEP_OUT));
endmodule
bind digital_io_conditioning digital_io_conditioning_checker
    digital_io_conditioning_checker_i (.*);

// ### bench/dio_far_side.sv
/*
 * Pin switches and a step source on pin 2.
 * Assumes driven pins loop back.
 */
`timescale 1ns/10ps
module dio_far_side (
    input wire logic clk_in,
    input wire logic [5:0] sw_in,
    input wire logic step_go_in,
    input wire logic [3:0] oe_in,
    input wire logic [3:0] drv_in,
    output logic [5:0] pin_out
);
    logic [2:0] ph_r = 3'h0;
    logic step_r = 1'b0;
    logic [3:0] ext;
    always @(posedge clk_in) begin
        ph_r <= step_go_in ? ph_r + 3'h1 : 3'h0;
        step_r <= step_go_in ? step_r ^ (ph_r == 3'h7) : 1'b0;
    end
    assign ext = {sw_in[3:2], step_go_in ? step_r : sw_in[1], sw_in[0]};
    assign pin_out = {sw_in[5:4], (oe_in & drv_in) | (~oe_in & ext)};
endmodule

// ### bench/digital_io_conditioning_tb.sv
/*
 * Bench with a reference model.
 * Assumes the package compiled first.
 */
`timescale 1ns/10ps
module digital_io_conditioning_tb;
    import dio_pkg::*;
    localparam int SP = 8;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic step_go = 1'b0;
    logic ce = 1'b1;
    logic [15:0] idx = 16'h0;
    logic [7:0] sub = 8'h0;
    logic [31:0] wd = 32'h0;
    logic [5:0] sw = 6'h0;
    logic [5:0] sens = 6'h0;
    logic [5:0] pin;
    logic [3:0] oe, po, pu, pd, m_dir, m_pull;
    logic [31:0] rdat, img, t, m_out;
    logic ack, err, brk, stp, dro;
    logic m_rte = 1'b0;
    logic [31:0] m_ctl [1:4] = '{default: 32'h0};
    logic [7:0] m_sel [32] = '{default: 8'h00};
    logic [6:0] codes [16] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07,
        7'h10, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46, 7'h47};
    logic [31:0] seed = 32'h63;
    int n_errors = 0;
    int compares = 0;
    int cyc = 0;
    always #20 clk = ~clk;
    dio_far_side dio_far_side_i (.clk_in(clk), .sw_in(sw), .step_go_in(step_go), .oe_in(oe),
        .drv_in(po), .pin_out(pin));
    digital_io_conditioning #(.SAMPLE_PERIOD(SP)) digital_io_conditioning_i (
        .MCLK_IN(clk), .RST_IN(rst), .CE_IN(ce),
        .GP_PIN_ONE_IN(pin[0]), .GP_PIN_ONE_OUT(po[0]), .GP_PIN_ONE_OE_OUT(oe[0]),
        .GP_PIN_TWO_STEP_IN(pin[1]), .GP_PIN_TWO_STEP_OUT(po[1]), .GP_PIN_TWO_STEP_OE_OUT(oe[1]),
        .GP_PIN_THREE_DIR_IN(pin[2]), .GP_PIN_THREE_DIR_OUT(po[2]), .GP_PIN_THREE_DIR_OE_OUT(oe[2]),
        .GP_PIN_FOUR_IN(pin[3]), .GP_PIN_FOUR_OUT(po[3]), .GP_PIN_FOUR_OE_OUT(oe[3]),
        .GP_PIN_FIVE_IN(pin[4]), .GP_PIN_SIX_IN(pin[5]), .SENSOR_IN(sens), .PULL_UP_OUT(pu),
        .PULL_DOWN_OUT(pd), .OD_RD_IN(rd), .OD_WR_IN(wr), .OD_INDEX_IN(idx), .OD_SUB_IN(sub),
        .OD_WDATA_IN(wd), .OD_RDATA_OUT(rdat), .OD_ACK_OUT(ack), .OD_ERR_OUT(err),
        .INPUT_IMAGE_OUT(img), .BRAKE_OUT(brk), .STEP_OUT(stp), .DIR_OUT(dro));
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    function automatic logic lvl(input int i);
        if (i < 4 && m_dir[i]) return m_out[16 + i];
        return sw[i];
    endfunction
    function automatic logic [5:0] raw_exp();
        logic [5:0] r;
        for (int i = 0; i < 6; i++) r[i] = lvl(i);
        return r;
    endfunction
    function automatic logic [31:0] exp_img();
        logic [31:0] r;
        logic p;
        int c;
        r = 32'h0;
        for (int i = 0; i < 6; i++) begin
            p = m_ctl[3][i] ? m_ctl[4][i] : lvl(i) ^ m_ctl[2][i];
            r[16 + i] = p;
            r[i] = p & m_ctl[1][i];
        end
        for (int k = 0; k < 32 && m_rte; k++) begin
            c = int'(m_sel[k][6:0]);
            p = (c >= 1 && c <= 6) ? lvl(c - 1) : (c >= 65 && c <= 70) ? sens[c - 65] : 1'b0;
            r[k] = p ^ m_sel[k][7];
        end
        return r;
    endfunction
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic od(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        idx <= i;
        sub <= s;
        wd <= d;
        @(posedge clk);
        rd <= 1'b0;
        wr <= 1'b0;
        #1;
        chk("ack", {31'h0, ack}, 32'h1);
    endtask
    task automatic rdc(input string nm, input logic [15:0] i, input logic [7:0] s, input logic [31:0] e);
        od(1'b0, i, s, 32'h0);
        chk(nm, rdat, e);
    endtask
    task automatic look();
        repeat (3 * SP + 8) @(posedge clk);
        #1;
        chk("image port", img, exp_img());
        rdc("image word", IDX_IN_IMAGE, SUB_IN_IMAGE, exp_img());
        rdc("raw word", IDX_IN_CTRL, SUB_RAW, {26'h0, raw_exp()});
    endtask
    task automatic complete_run();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_errors++;
            complete_run();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("pin state", {16'h0, oe, pu, pd, po}, 32'hf0);
        rdc("dir mask", IDX_FLEX_CFG, SUB_DIR_MASK, 32'h0);
        rdc("pull mask", IDX_FLEX_CFG, SUB_PULL_MASK, 32'h0);
        for (int s = 1; s < 9; s++) begin
            rdc("ctrl word", IDX_IN_CTRL, 8'(s), 32'h0);
        end
        for (int n = 0; n < 8; n++) begin
            t = rnd();
            m_dir = t[3:0];
            m_pull = t[7:4];
            m_out = rnd() & 32'hf0001;
            @(posedge clk);
            sw <= t[13:8];
            sens <= t[21:16];
            od(1'b1, IDX_FLEX_CFG, SUB_DIR_MASK, {28'h0, m_dir});
            od(1'b1, IDX_FLEX_CFG, SUB_PULL_MASK, {28'h0, m_pull});
            od(1'b1, IDX_OUT_IMAGE, SUB_OUT_IMAGE, m_out);
            for (int k = 1; k < 5; k++) begin
                m_ctl[k] = rnd() & 32'h3f;
                od(1'b1, IDX_IN_CTRL, 8'(k), m_ctl[k]);
            end
            look();
            chk("pins", {15'h0, brk, oe, pu, pd, po},
                {15'h0, m_out[0], m_dir, m_pull & ~m_dir, ~m_pull & ~m_dir, m_out[19:16]});
            rdc("out image", IDX_OUT_IMAGE, SUB_OUT_IMAGE, m_out);
            rdc("pull mask", IDX_FLEX_CFG, SUB_PULL_MASK, {28'h0, m_pull});
        end
        m_rte = 1'b1;
        od(1'b1, IDX_IN_CTRL, SUB_ROUTE_EN, 32'h1);
        for (int k = 0; k < 32; k++) begin
            t = rnd();
            m_sel[k] = {t[0], codes[k % 16]};
            od(1'b1, IDX_ROUTE_SEL, 8'(k + 1), {24'h0, m_sel[k]});
            rdc("selector", IDX_ROUTE_SEL, 8'(k + 1), {24'h0, m_sel[k]});
        end
        @(posedge clk);
        sw <= 6'(rnd());
        sens <= 6'(rnd());
        look();
        m_rte = 1'b0;
        od(1'b1, IDX_IN_CTRL, SUB_ROUTE_EN, 32'h0);
        for (int k = 1; k < 5; k++) begin
            m_ctl[k] = 32'h0;
            od(1'b1, IDX_IN_CTRL, 8'(k), 32'h0);
        end
        m_dir = 4'h0;
        od(1'b1, IDX_FLEX_CFG, SUB_DIR_MASK, 32'h0);
        @(posedge clk);
        sw <= 6'h0;
        look();
        @(posedge clk);
        sw <= 6'h30;
        repeat (SP - 3) @(posedge clk);
        sw <= 6'h0;
        look();
        @(posedge clk);
        sw <= 6'h30;
        look();
        m_ctl[2] = 32'h6;
        od(1'b1, IDX_IN_CTRL, SUB_INVERT, m_ctl[2]);
        @(posedge clk);
        sw <= 6'h04;
        step_go <= 1'b1;
        repeat (64) @(posedge clk);
        step_go <= 1'b0;
        #1;
        chk("direction", {31'h0, dro}, 32'h1);
        od(1'b1, IDX_IN_CTRL, SUB_RAW, 32'hffff_ffff);
        chk("raw write", {31'h0, err}, 32'h1);
        od(1'b1, IDX_IN_IMAGE, SUB_IN_IMAGE, 32'hffff_ffff);
        chk("image write", {31'h0, err}, 32'h1);
        rdc("selector range", IDX_ROUTE_SEL, 8'h21, 32'h0);
        chk("selector err", {31'h0, err}, 32'h1);
        look();
        t = exp_img();
        @(posedge clk);
        ce <= 1'b0;
        sw <= 6'h35;
        repeat (3 * SP) @(posedge clk);
        ce <= 1'b1;
        #1;
        chk("frozen image", img, t);
        complete_run();
    end
endmodule
